// ### shared/tpwm_pkg.sv
// register map, field positions and reset values of the two-compare pwm timer
// assumes a 32-bit ahb-lite slave port, one aligned word per register
package tpwm_pkg;
    localparam logic [7:0]  MODE_OFS = 8'h00;
    localparam logic [7:0]  CR1_OFS  = 8'h04;
    localparam logic [7:0]  CR2_OFS  = 8'h08;
    localparam logic [7:0]  CNT_OFS  = 8'h0C;
    localparam logic [7:0]  GRA_OFS  = 8'h10;
    localparam logic [7:0]  GRB_OFS  = 8'h14;
    localparam logic [7:0]  GRC_OFS  = 8'h18;
    localparam logic [7:0]  OER_OFS  = 8'h1C;
    localparam logic [7:0]  SR_OFS   = 8'h20;
    localparam logic [7:0]  IER_OFS  = 8'h24;

    localparam int unsigned MODE_TWOCMP_B  = 3;
    localparam int unsigned MODE_THIRDFN_B = 4;
    localparam int unsigned MODE_START_B   = 7;
    localparam int unsigned CR1_LVL_B      = 1;
    localparam int unsigned CR1_SRC_LO     = 4;
    localparam int unsigned CR1_CLR_B      = 7;
    localparam int unsigned CR2_CONT_B     = 5;
    localparam int unsigned CR2_EDGE_LO    = 6;
    localparam int unsigned OER_DIS_B      = 1;
    localparam int unsigned OER_CUT_B      = 7;
    localparam int unsigned SR_MATCHA_B    = 0;
    localparam int unsigned SR_WRAP_B      = 7;

    localparam logic [7:0]  MODE_RST = 8'h00;
    localparam logic [7:0]  CR1_RST  = 8'h00;
    localparam logic [7:0]  CR2_RST  = 8'h00;
    localparam logic [7:0]  OER_RST  = 8'h02;
    localparam logic [7:0]  IER_RST  = 8'h00;
    localparam logic [15:0] CNT_RST  = 16'h0000;
    localparam logic [15:0] GR_RST   = 16'hFFFF;
    localparam logic [15:0] CNT_MAX  = 16'hFFFF;

    typedef struct packed {
        logic level;
        logic oe;
    } tpwm_pin_t;
endpackage

// ### hw/tpwm_top.sv
// two-compare pwm timer channel with ahb-lite register slave
// assumes trigger and cutoff pins are asynchronous, one 50 mhz clock
// Function
// [RULE1] mode bit 3 zero selects two-compare pwm
// [RULE2] third compare stays general register when bit4 zero
// [RULE3] counter stopped until count start bit set
// [RULE4] output starts low, high at third, low second
// [RULE5] count source 000 is undivided clock
// [RULE6] clear bit set: period match zeroes counter
// [RULE7] count operation zero: keep counting after match
// [RULE8] trigger edge bits 00 ignore trigger pin
// [RULE9] 16-bit up counter, software readable and writable
// [RULE10] wrap past maximum sets overflow flag
// [RULE11] first compare defines period, all sixteen bits
// [RULE12] second compare gives trailing output change
// [RULE13] third compare gives leading change, wait time
// [RULE14] output driven only while disable bit zero
// [RULE15] cutoff enable zero ignores cutoff input
// [RULE16] flag a clears by write zero after read
// [RULE17] enable bit 0 raises match a interrupt
// [RULE18] flag a set in period match cycle
`timescale 1ns/1ns
module tpwm_top
(
    input  wire logic                CLK_I,
    input  wire logic                RST_I,
    input  wire logic                HSEL_I,
    input  wire logic [31:0]         HADDR_I,
    input  wire logic [1:0]          HTRANS_I,
    input  wire logic                HWRITE_I,
    input  wire logic [2:0]          HSIZE_I,
    input  wire logic [31:0]         HWDATA_I,
    input  wire logic                HREADY_I,
    output logic      [31:0]         HRDATA_O,
    output logic                     HREADYOUT_O,
    output logic                     HRESP_O,
    input  wire logic                TRIG_I,
    input  wire logic                CUTOFF_N_I,
    output tpwm_pkg::tpwm_pin_t      PIN_O,
    output logic                     IRQ_O
);
    import tpwm_pkg::*;

    logic [7:0]  mode_q;
    logic [7:0]  cr1_q;
    logic [7:0]  cr2_q;
    logic [7:0]  oer_q;
    logic [7:0]  ier_q;
    logic [15:0] cnt_q;
    logic [15:0] gra_q;
    logic [15:0] grb_q;
    logic [15:0] grc_q;
    logic        flag_a_q;
    logic        wrap_q;
    logic        arm_a_q;
    logic        arm_wrap_q;
    logic        pwm_q;
    logic        start_prev_q;
    logic [6:0]  pre_q;
    logic        trig1_q;
    logic        trig2_q;
    logic        trig3_q;
    logic        cut1_q;
    logic        cut2_q;
    logic        dp_wr_q;
    logic        dp_rd_q;
    logic        rd_done_q;
    logic [7:0]  dp_addr_q;
    logic [31:0] rdata_q;

    logic        ap_valid;
    logic        wr_en;
    logic [31:0] rd_mux;
    logic [6:0]  pre_mask;
    logic        tick;
    logic        run;
    logic        gra_hit;
    logic        cnt_wr;
    logic        trig_evt;
    logic        trig_rise;
    logic        trig_fall;
    logic        step;
    logic        clr_hit;
    logic        wrap_evt;
    logic        flag_a_set;
    logic        cont_stop;
    logic [1:0]  edge_sel;
    logic [2:0]  src_sel;
    logic        lvl_sel;
    logic        sr_wr;

    // bus slave: writes complete with no wait, reads take one wait state
    assign ap_valid    = HSEL_I & HTRANS_I[1] & HREADY_I;
    assign wr_en       = dp_wr_q;
    assign HREADYOUT_O = ~(dp_rd_q & ~rd_done_q);
    assign HRESP_O     = 1'b0;
    assign HRDATA_O    = rdata_q;

    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            dp_wr_q   <= 1'b0;
            dp_rd_q   <= 1'b0;
            dp_addr_q <= 8'h00;
        end
        else if (HREADYOUT_O)
        begin
            dp_wr_q   <= ap_valid & HWRITE_I;
            dp_rd_q   <= ap_valid & ~HWRITE_I;
            dp_addr_q <= (HADDR_I[31:8] == 24'h000000) ? HADDR_I[7:0]
                                                        : 8'hFF;
        end
    end

    always_comb
    begin
        case (dp_addr_q)
            MODE_OFS: rd_mux = {24'h000000, mode_q};
            CR1_OFS:  rd_mux = {24'h000000, cr1_q};
            CR2_OFS:  rd_mux = {24'h000000, cr2_q};
            CNT_OFS:  rd_mux = {16'h0000, cnt_q};
            GRA_OFS:  rd_mux = {16'h0000, gra_q};
            GRB_OFS:  rd_mux = {16'h0000, grb_q};
            GRC_OFS:  rd_mux = {16'h0000, grc_q};
            OER_OFS:  rd_mux = {24'h000000, oer_q};
            SR_OFS:   rd_mux = {24'h000000, wrap_q, 6'h00, flag_a_q};
            IER_OFS:  rd_mux = {24'h000000, ier_q};
            default:  rd_mux = 32'h00000000;
        endcase
    end

    // read data is latched in the wait cycle so it sees prior writes
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            rd_done_q <= 1'b0;
            rdata_q   <= 32'h00000000;
        end
        else
        begin
            rd_done_q <= dp_rd_q & ~rd_done_q;
            if (dp_rd_q & ~rd_done_q)
                rdata_q <= rd_mux;
        end
    end

    assign sr_wr = wr_en & (dp_addr_q == SR_OFS);
    assign cnt_wr = wr_en & (dp_addr_q == CNT_OFS);

    // configuration registers
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            cr1_q <= CR1_RST;
            cr2_q <= CR2_RST;
            ier_q <= IER_RST;
            gra_q <= GR_RST;
            grb_q <= GR_RST;
            grc_q <= GR_RST;
        end
        else if (wr_en)
        begin
            case (dp_addr_q)
                CR1_OFS: cr1_q <= HWDATA_I[7:0];
                CR2_OFS: cr2_q <= HWDATA_I[7:0];
                IER_OFS: ier_q <= HWDATA_I[7:0];
                GRA_OFS: gra_q <= HWDATA_I[15:0]; // RULE11
                GRB_OFS: grb_q <= HWDATA_I[15:0]; // RULE12
                // general compare only, no buffering
                GRC_OFS: grc_q <= HWDATA_I[15:0]; // RULE2 RULE13
                default: ;
            endcase
        end
    end

    assign lvl_sel  = cr1_q[CR1_LVL_B];
    assign src_sel  = cr1_q[CR1_SRC_LO +: 3];
    assign edge_sel = cr2_q[CR2_EDGE_LO +: 2];

    // count source: 000 every clock, otherwise divide by 2**select
    assign pre_mask = 7'((8'h01 << src_sel) - 8'h01);
    assign tick     = ((pre_q | ~pre_mask) == 7'h7F); // RULE5

    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
            pre_q <= 7'h00;
        else
            pre_q <= pre_q + 7'h01;
    end

    // trigger pin synchroniser and edge select
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            trig1_q <= 1'b0;
            trig2_q <= 1'b0;
            trig3_q <= 1'b0;
            cut1_q  <= 1'b1;
            cut2_q  <= 1'b1;
        end
        else
        begin
            trig1_q <= TRIG_I;
            trig2_q <= trig1_q;
            trig3_q <= trig2_q;
            cut1_q  <= CUTOFF_N_I;
            cut2_q  <= cut1_q;
        end
    end

    assign trig_rise = trig2_q & ~trig3_q;
    assign trig_fall = ~trig2_q & trig3_q;
    always_comb
    begin
        case (edge_sel)
            2'b01:   trig_evt = trig_rise;
            2'b10:   trig_evt = trig_fall;
            2'b11:   trig_evt = trig_rise | trig_fall;
            default: trig_evt = 1'b0; // RULE8
        endcase
    end

    // counter core
    assign run       = mode_q[MODE_START_B];
    assign gra_hit   = (cnt_q == gra_q); // RULE11
    assign step      = run & tick;
    assign clr_hit    = step & gra_hit & cr1_q[CR1_CLR_B];
    assign wrap_evt   = step & (cnt_q == CNT_MAX) & ~clr_hit;
    assign flag_a_set = step & gra_hit; // RULE18
    assign cont_stop  = step & gra_hit & cr2_q[CR2_CONT_B]; // RULE7

    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
            mode_q <= MODE_RST;
        else if (wr_en & (dp_addr_q == MODE_OFS))
            mode_q <= HWDATA_I[7:0];
        else if (cont_stop)
            mode_q[MODE_START_B] <= 1'b0;
    end

    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
            cnt_q <= CNT_RST;
        else if (cnt_wr)
            cnt_q <= HWDATA_I[15:0]; // RULE9
        else if (trig_evt)
            cnt_q <= CNT_RST;
        else if (clr_hit)
            cnt_q <= CNT_RST; // RULE6
        else if (step)
            cnt_q <= cnt_q + 16'h0001; // RULE3 RULE9
    end

    // status flags: set wins, cleared by writing zero after reading one
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            flag_a_q   <= 1'b0;
            wrap_q     <= 1'b0;
            arm_a_q    <= 1'b0;
            arm_wrap_q <= 1'b0;
        end
        else
        begin
            if (flag_a_set)
                flag_a_q <= 1'b1; // RULE18
            else if (sr_wr & arm_a_q & ~HWDATA_I[SR_MATCHA_B])
                flag_a_q <= 1'b0; // RULE16
            if (wrap_evt)
                wrap_q <= 1'b1; // RULE10
            else if (sr_wr & arm_wrap_q & ~HWDATA_I[SR_WRAP_B])
                wrap_q <= 1'b0;
            if (dp_rd_q & ~rd_done_q & (dp_addr_q == SR_OFS))
            begin
                arm_a_q    <= flag_a_q;
                arm_wrap_q <= wrap_q;
            end
            else if (sr_wr)
            begin
                arm_a_q    <= 1'b0;
                arm_wrap_q <= 1'b0;
            end
        end
    end

    assign IRQ_O = (flag_a_q & ier_q[SR_MATCHA_B])
                 | (wrap_q & ier_q[SR_WRAP_B]); // RULE17

    // output enable register, cutoff forces the disable bit
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
            oer_q <= OER_RST;
        else if (wr_en & (dp_addr_q == OER_OFS))
            oer_q <= HWDATA_I[7:0];
        else if (oer_q[OER_CUT_B] & ~cut2_q)
            oer_q[OER_DIS_B] <= 1'b1; // RULE15
    end

    // pwm level: inactive at start, leading at third, trailing at second
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            pwm_q        <= 1'b0;
            start_prev_q <= 1'b0;
        end
        else
        begin
            start_prev_q <= run;
            if (mode_q[MODE_TWOCMP_B])
                pwm_q <= lvl_sel;
            else if ((run & ~start_prev_q) | trig_evt)
                pwm_q <= lvl_sel; // RULE1 RULE4
            else if (step & (cnt_q == grb_q))
                pwm_q <= lvl_sel; // RULE4 RULE12
            else if (step & (cnt_q == grc_q))
                pwm_q <= ~lvl_sel; // RULE4 RULE13
        end
    end

    assign PIN_O.level = pwm_q;
    assign PIN_O.oe    = ~oer_q[OER_DIS_B]; // RULE14

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    AST_STOP: assert property ( // RULE3
        (!run && !cnt_wr && !trig_evt) |=> $stable(cnt_q))
        else $error("counter moved while stopped");

    AST_CLEAR: assert property ( // RULE6
        (clr_hit && !cnt_wr && !trig_evt) |=> (cnt_q == 16'h0000))
        else $error("period match did not clear counter");

    AST_INC: assert property ( // RULE9
        (step && !gra_hit && !cnt_wr && !trig_evt)
        |=> (cnt_q == 16'($past(cnt_q) + 16'h0001)))
        else $error("counter did not increment");

    AST_OVF: assert property ( // RULE10
        wrap_evt |=> wrap_q)
        else $error("overflow flag not set on wrap");

    AST_FLAGA: assert property ( // RULE18
        (step && gra_hit) |=> flag_a_q)
        else $error("flag a not set on period match");

    AST_NOCLR: assert property ( // RULE16
        (flag_a_q && sr_wr && !arm_a_q) |=> flag_a_q)
        else $error("flag a cleared without prior read");

    AST_IRQ: assert property ( // RULE17
        (flag_a_q && ier_q[SR_MATCHA_B]) |-> IRQ_O)
        else $error("match a interrupt missing");

    AST_OE: assert property ( // RULE14
        oer_q[OER_DIS_B] |-> !PIN_O.oe)
        else $error("output driven while disabled");

    AST_LEAD: assert property ( // RULE4
        (!mode_q[MODE_TWOCMP_B] && step && start_prev_q && !trig_evt
         && cnt_q == grc_q && cnt_q != grb_q) |=> (pwm_q == !$past(lvl_sel)))
        else $error("leading edge missed");

    AST_SRC: assert property ( // RULE5
        (src_sel == 3'b000 && run && !cnt_wr && !trig_evt && !gra_hit)
        |=> (cnt_q != $past(cnt_q)))
        else $error("undivided source not ticking");

    AST_CONT: assert property ( // RULE7
        (step && gra_hit && !cr2_q[CR2_CONT_B] && !wr_en) |=> run)
        else $error("counter stopped at period match");

    AST_TRIG: assert property ( // RULE8
        (edge_sel == 2'b00 && !cnt_wr && !step) |=> $stable(cnt_q))
        else $error("trigger accepted while disabled");
endmodule

// ### test/tpwm_top_tb.sv
// self-checking bench for the two-compare pwm timer channel
// assumes tpwm_pkg and tpwm_top compiled first; one 50 mhz clock
`timescale 1ns/1ns
module tpwm_top_tb;
    import tpwm_pkg::*;
    logic        clk;
    logic        rst;
    logic        hsel;
    logic        hwrite;
    logic        rdy;
    logic        hresp;
    logic        trig;
    logic        cut_n;
    logic        irq;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    tpwm_pin_t   pin;
    int          bad_count;
    int          n_checks;
    int          hi;
    int          lo;
    int          n;

    tpwm_top dut_u
    (
        .CLK_I       (clk),
        .RST_I       (rst),
        .HSEL_I      (hsel),
        .HADDR_I     (haddr),
        .HTRANS_I    (htrans),
        .HWRITE_I    (hwrite),
        .HSIZE_I     (hsize),
        .HWDATA_I    (hwdata),
        .HREADY_I    (rdy),
        .HRDATA_O    (hrdata),
        .HREADYOUT_O (rdy),
        .HRESP_O     (hresp),
        .TRIG_I      (trig),
        .CUTOFF_N_I  (cut_n),
        .PIN_O       (pin),
        .IRQ_O       (irq)
    );

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string msg);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: %s seen %h expected %h",
                     $time, msg, seen, exp);
        end
    endtask

    // edge-sampled: values read just after the edge are pre-edge values
    task automatic wait_rdy;
        int k;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (rdy !== 1'b1 && k < 20);
        if (rdy !== 1'b1)
        begin
            bad_count++;
            complete_run();
        end
    endtask

    task automatic bus_go(input logic [31:0] a, input logic w);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= w;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'b00;
    endtask

    task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
        bus_go(a, 1'b1);
        hwdata <= d;
        wait_rdy();
    endtask

    task automatic bus_rd(input logic [31:0] a, output logic [31:0] d);
        bus_go(a, 1'b0);
        wait_rdy();
        d = hrdata;
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] v;
        bus_rd(a, v);
        check(v, exp, "register read");
        check({31'h0, hresp}, 32'h0, "bus response");
    endtask

    // one more edge so that updates of the last edge have landed
    task automatic pin_chk(input logic [31:0] seen_sel,
                           input logic [31:0] exp);
        @(posedge clk);
        check(seen_sel == 0 ? {31'h0, pin.oe} :
              seen_sel == 1 ? {31'h0, pin.level} : {31'h0, irq},
              exp, "pin or irq");
    endtask

    task automatic wait_lvl(input logic v, output int k);
        k = 0;
        while (pin.level !== v && k < 100)
        begin
            @(posedge clk);
            k++;
        end
        if (k >= 100)
        begin
            bad_count++;
            complete_run();
        end
    endtask

    initial
    begin
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        trig = 1'b0;
        cut_n = 1'b1;
        bad_count = 0;
        n_checks = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_chk(MODE_OFS, MODE_RST);
        rd_chk(CR1_OFS, CR1_RST);
        rd_chk(CR2_OFS, CR2_RST);
        rd_chk(CNT_OFS, CNT_RST);
        rd_chk(GRA_OFS, GR_RST);
        rd_chk(GRB_OFS, GR_RST);
        rd_chk(GRC_OFS, GR_RST);
        rd_chk(OER_OFS, OER_RST);
        rd_chk(SR_OFS, 32'h0);
        rd_chk(IER_OFS, IER_RST);
        bus_wr(32'h100, 32'hFFFF_FFFF);
        rd_chk(32'h100, 32'h0);
        pin_chk(0, 0);
        bus_wr(GRA_OFS, 32'h9);
        bus_wr(GRB_OFS, 32'h6);
        bus_wr(GRC_OFS, 32'h3);
        bus_wr(CR1_OFS, 32'h80);
        bus_wr(CR2_OFS, 32'h0);
        bus_wr(OER_OFS, 32'h0);
        bus_wr(IER_OFS, 32'h1);
        rd_chk(GRA_OFS, 32'h9);
        rd_chk(GRC_OFS, 32'h3);
        cut_n <= 1'b0;
        trig <= 1'b1;
        pin_chk(0, 1);
        bus_wr(MODE_OFS, 32'h80);
        pin_chk(1, 0);
        wait_lvl(1'b1, n);
        trig <= 1'b0;
        wait_lvl(1'b0, hi);
        wait_lvl(1'b1, lo);
        check(hi, 32'd3, "high time");
        check(lo, 32'd7, "low time");
        wait_lvl(1'b0, hi);
        check(hi, 32'd3, "second high time");
        pin_chk(2, 1);
        bus_wr(MODE_OFS, 32'h0);
        bus_wr(SR_OFS, 32'h0);
        rd_chk(SR_OFS, 32'h1);
        bus_wr(IER_OFS, 32'h0);
        pin_chk(2, 0);
        bus_wr(IER_OFS, 32'h1);
        pin_chk(2, 1);
        bus_wr(SR_OFS, 32'h0);
        rd_chk(SR_OFS, 32'h0);
        pin_chk(2, 0);
        bus_wr(CNT_OFS, 32'h5);
        rd_chk(CNT_OFS, 32'h5);
        repeat (5) @(posedge clk);
        rd_chk(CNT_OFS, 32'h5);
        bus_wr(CR1_OFS, 32'h0);
        bus_wr(CNT_OFS, 32'hFFFE);
        bus_wr(MODE_OFS, 32'h80);
        repeat (4) @(posedge clk);
        bus_wr(MODE_OFS, 32'h0);
        bus_rd(SR_OFS, rd);
        check(rd & 32'h80, 32'h80, "overflow flag");
        bus_wr(CNT_OFS, 32'h0);
        bus_wr(MODE_OFS, 32'h88);
        repeat (4) @(posedge clk);
        pin_chk(1, 0);
        bus_wr(MODE_OFS, 32'h0);
        bus_wr(OER_OFS, 32'h2);
        pin_chk(0, 0);
        complete_run();
    end
endmodule
